// ### pkg/supply_monitor_pkg.sv
// Package with register map, field layout and types of the supply monitor control.
package supply_monitor_pkg;

  // Register byte addresses.
  localparam logic [15:0] DETECTOR_ENABLE_ADDR = 16'h5100;
  localparam logic [15:0] DETECTOR_LEVEL_SELECT_ADDR = 16'h5101;
  localparam logic [15:0] DETECTOR_RESULT_ADDR = 16'h5102;

  // Field positions and widths.
  localparam int DETECT_ENABLE_BIT_POS = 0;
  localparam int LOW_SUPPLY_RESULT_BIT_POS = 0;
  localparam int LEVEL_SELECT_WIDTH = 5;

  // Reset values.
  localparam logic DETECT_ENABLE_RESET = 1'h0;
  localparam logic [4:0] LEVEL_SELECT_RESET = 5'h00;
  localparam logic LOW_SUPPLY_RESULT_RESET = 1'h0;

  // Valid level select codes, highest and lowest comparison level.
  localparam logic [4:0] LEVEL_CODE_MAX = 5'h1a;
  localparam logic [4:0] LEVEL_CODE_MIN = 5'h0e;

  // Register bus request carried as one struct.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Detector operating state, Gray coded along idle -> run.
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } monitor_state_t;

endpackage : supply_monitor_pkg

// ### core/supply_voltage_detect_ctrl.sv
// Register-side control of the supply voltage detector with frozen result on stop.
// Summary of operation
// - Writing one to the enable bit starts comparison against the selected level.
// - Writing zero to enable captures the present comparator outcome, holds it, stops.
// - While enabled the result bit follows the live comparator outcome.
// - Result reads one for supply below level, zero at or above it.
// - Codes 0x1a down to 0xe select thirteen levels; other codes are reserved.
// - The reference follows the current level code, even while detection runs.
// - After reset enable is zero and the level select holds code zero.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module supply_voltage_detect_ctrl
  import supply_monitor_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_cmp_low,
  output logic o_detector_on,
  output logic [4:0] o_level_code,
  output logic o_level_valid
);

  reg_req_t req;
  monitor_state_t state;
  monitor_state_t next_state;
  logic detect_enable_bit;
  logic [4:0] level_select_field;
  logic low_supply_result_bit;
  logic enable_write;
  logic level_write;

  // True when a level code names one of the thirteen real comparison levels.
  function automatic logic level_code_ok(input logic [4:0] code);
    level_code_ok = (code >= LEVEL_CODE_MIN) && (code <= LEVEL_CODE_MAX);
  endfunction

  // Bundle the bus request and decode write targets.
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign enable_write = req.wr && (req.addr == DETECTOR_ENABLE_ADDR);
  assign level_write = req.wr && (req.addr == DETECTOR_LEVEL_SELECT_ADDR);

  // Enable bit register; only bit zero is stored, the rest is reserved.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      detect_enable_bit <= DETECT_ENABLE_RESET;
    end else if (enable_write) begin
      detect_enable_bit <= req.wdata[DETECT_ENABLE_BIT_POS];
    end
  end

  // Level select register; reserved codes are stored as written, the comparator decides.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      level_select_field <= LEVEL_SELECT_RESET;
    end else if (level_write) begin
      level_select_field <= req.wdata[LEVEL_SELECT_WIDTH-1:0];
    end
  end

  // Run state tracks the enable bit so the analog side is powered only when needed.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (detect_enable_bit) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!detect_enable_bit) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Result bit samples the comparator while enabled. The write of zero to enable takes
  // one last sample in that same cycle, so the value seen at the stop is the one frozen.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_supply_result_bit <= LOW_SUPPLY_RESULT_RESET;
    end else if (detect_enable_bit) begin
      low_supply_result_bit <= i_cmp_low;
    end
  end

  // Analog side controls. The reference is driven straight from the register so a new
  // code applies at once; software must still allow the settling time before trusting it.
  // Live reference code.
  assign o_level_code = level_select_field;
  assign o_level_valid = level_code_ok(level_select_field);
  assign o_detector_on = (state == ST_RUN);

  // Read data stand in the cycle after the read strobe; unmapped addresses read zero.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        DETECTOR_ENABLE_ADDR: o_rdata <= {7'h00, detect_enable_bit};
        DETECTOR_LEVEL_SELECT_ADDR: o_rdata <= {3'h0, level_select_field};
        DETECTOR_RESULT_ADDR: o_rdata <= {7'h00, low_supply_result_bit};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // supply_voltage_detect_ctrl

`default_nettype wire

// ### bench/supply_monitor_checker.sv
// Port checker of the supply monitor control.
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_checker
  import supply_monitor_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_cmp_low,
  input wire logic o_detector_on,
  input wire logic [4:0] o_level_code,
  input wire logic o_level_valid
);
  logic en_m;
  logic res_m;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Shadow enable and result; the write of zero still samples, which freezes the result.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_m <= 1'b0;
      res_m <= 1'b0;
    end else begin
      if (en_m) res_m <= i_cmp_low;
      if (i_wr && i_addr == DETECTOR_ENABLE_ADDR) en_m <= i_wdata[0];
    end
  end
  sequence rd_res_s;
    i_rd && i_addr == DETECTOR_RESULT_ADDR;
  endsequence
  on_follow_a: assert property (o_detector_on == $past(en_m))
    else $error("detector on lag");
  live_result_a: assert property (rd_res_s ##0 en_m |=> o_rdata[0] == $past(res_m))
    else $error("live result");
  held_result_a: assert property (rd_res_s ##0 !en_m |=> o_rdata == {7'h00, $past(res_m)})
    else $error("held result");
  code_valid_a: assert property (o_level_valid == (o_level_code inside {[5'h0e:5'h1a]}))
    else $error("level valid");
  code_write_a: assert property (i_wr && i_addr == DETECTOR_LEVEL_SELECT_ADDR |=>
    o_level_code == $past(i_wdata[4:0])) else $error("level code");
  reset_val_a: assert property ($rose(i_resetn) |-> o_level_code == 5'h00 && !o_detector_on)
    else $error("reset value");
  en_read_a: assert property (i_rd && i_addr == DETECTOR_ENABLE_ADDR |=>
    o_rdata == {7'h00, $past(en_m)}) else $error("enable read");
  lvl_read_a: assert property (i_rd && i_addr == DETECTOR_LEVEL_SELECT_ADDR |=>
    o_rdata == {3'h0, $past(o_level_code)}) else $error("level read");
endmodule // supply_monitor_checker
bind supply_voltage_detect_ctrl supply_monitor_checker chk (.*);
`default_nettype wire

// ### bench/supply_voltage_detect_ctrl_bench.sv
// Random register and comparator traffic for the supply monitor control.
`timescale 1ns/10ps
`default_nettype none
module supply_voltage_detect_ctrl_bench
  import supply_monitor_pkg::*;
;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t mismatch", $time); end end
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, cmp = 1'b0, on, vld;
  logic en_b, on_b, r_b;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00, rdata, exp_rd;
  logic [4:0] code, lv_b;
  int error_cnt = 0, n_checks = 0;
  always #2 clk = ~clk;
  supply_voltage_detect_ctrl uut (.i_ref_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cmp_low(cmp), .o_detector_on(on),
    .o_level_code(code), .o_level_valid(vld));
  function automatic logic valid_f(input logic [4:0] c);
    return c >= 5'h0e && c <= 5'h1a;
  endfunction
  // Reference registers; stale read data would show as a mismatch next cycle.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {en_b, on_b, r_b, lv_b, exp_rd} <= '0;
    end else begin
      if (en_b) r_b <= cmp;
      if (wr && addr == 16'h5100) en_b <= wd[0];
      if (wr && addr == 16'h5101) lv_b <= wd[4:0];
      on_b <= en_b;
      exp_rd <= !rd ? 8'h00 : addr == 16'h5100 ? {7'h00, en_b} : addr == 16'h5101 ?
        {3'h0, lv_b} : addr == 16'h5102 ? {7'h00, r_b} : 8'h00;
    end
  end
  // Outputs are settled at the falling edge.
  always @(negedge clk) begin
    if (rstn) begin
      `CHK(rdata, exp_rd)
      `CHK(on, on_b)
      `CHK(code, lv_b)
      `CHK(vld, valid_f(lv_b))
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog well past the 4000 cycles of traffic.
  initial begin
    #40000;
    error_cnt++;
    report_and_stop();
  end
  // Ops 0-2 write, 3-6 read the unmapped place and the three registers, 7 idles.
  initial begin
    int op;
    logic [31:0] v;
    void'($urandom(32'h126f9fcf));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      op = $urandom % 8;
      v = $urandom;
      // Comparator settles at once, so no response wait is needed here.
      cmp <= v[31];
      wr <= op < 3;
      rd <= op > 2 && op < 7;
      addr <= 16'h5100 + 16'(op % 4);
      // Reserved bits of enable and level select written as zero, the result address gets a random byte; enable is often cleared.
      wd <= op == 0 ? {7'h00, v[0]} : op == 1 ? {3'h0, v[4:0]} : v[7:0];
      rstn <= !(i > 2000 && i < 2004);
    end
    report_and_stop();
  end
endmodule // supply_voltage_detect_ctrl_bench
`default_nettype wire
